// [include/vdm_consts.svh]
// Constants of the voltage distortion monitor: offsets, fields, resets, timing.
// Assumes inclusion by bare name from a file that sees the include folder.
`ifndef VDM_CONSTS_SVH
`define VDM_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses; the log base in 32-byte entries)
// ----------------------------------------------------------------------------
`define VDM_OFS_CTRL 12'h000
`define VDM_OFS_THRESH 12'h004
`define VDM_OFS_DELAY 12'h008
`define VDM_OFS_EVTSEL 12'h00c
`define VDM_OFS_STATUS 12'h010
`define VDM_OFS_CNT_START 12'h014
`define VDM_OFS_CNT_ALARM 12'h018
`define VDM_OFS_CNT_BLOCK 12'h01c
`define VDM_OFS_CNT_CLR 12'h020
`define VDM_OFS_LOG_HEAD 12'h024
`define VDM_OFS_LOG_BASE 7'h08
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define VDM_CTRL_EN 0
`define VDM_CTRL_PWR 1
`define VDM_CTRL_MODE_LO 2
`define VDM_CTRL_ALLOW 5
`define VDM_RST_EN 1'b1
`define VDM_RST_PWR 1'b0
`define VDM_RST_THRESH 14'h03e8
`define VDM_THRESH_MIN 14'h000a
`define VDM_THRESH_MAX 14'h2710
`define VDM_RST_DELAY 19'h007d0
`define VDM_DELAY_MAX 19'h57e40
`define VDM_RST_EVTSEL 6'h3f
`define VDM_LOG_DEPTH 12
// ----------------------------------------------------------------------------
// Arithmetic and timing
// ----------------------------------------------------------------------------
`define VDM_SCALE 64'd10000
`define VDM_REL_PCT 64'd97
`define VDM_PCT 64'd100
`define VDM_CYCLE_US 5000
`define VDM_CLK_MHZ 50
`define VDM_CYCLE_CLKS (`VDM_CYCLE_US * `VDM_CLK_MHZ)
`define VDM_BLK_LEAD_MS 5
`endif

// [include/vdm_pkg.sv]
// Types of the voltage distortion monitor.
// Assumes nothing beyond a SystemVerilog compiler.
package vdm_pkg;
    typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_ALARM, COND_BLOCKED} vdm_cond_e;
    typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED,
                              MODE_OFF} vdm_mode_e;
    typedef struct packed {
        logic [15:0] harm_sq;
        logic [15:0] fund_sq;
    } vdm_meas_s;
    typedef struct packed {
        logic [47:0] stamp;
        logic [2:0] group;
        logic [2:0] code;
        vdm_meas_s [2:0] phase;
    } vdm_log_s;
    typedef struct packed {
        logic valid;
        logic [2:0] code;
        logic [47:0] stamp;
    } vdm_evt_s;
endpackage

// [verilog/vdm_monitor.sv]
// Voltage distortion monitor: three-phase distortion alarm with APB registers.
// Assumes measurements, time and setting group come from logic on pclk; the
// blocking input comes from outside and is synchronised here.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "vdm_consts.svh"

module vdm_monitor #(
    parameter int CYCLE_CLKS = `VDM_CYCLE_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_valid,
    input wire vdm_pkg::vdm_meas_s [2:0] meas_in,
    input wire logic block_in,
    input wire logic [47:0] time_ms,
    input wire logic [2:0] active_group,
    output logic start_out,
    output logic alarm_out,
    output logic blocked_out,
    output vdm_pkg::vdm_evt_s event_out
);
    import vdm_pkg::*;

    // ------------------------------------------------------------------------
    // Elaboration check and cycle tick
    // ------------------------------------------------------------------------
    if (CYCLE_CLKS < 2) begin : g_chk
        $error("CYCLE_CLKS must be at least 2");
    end

    localparam int TW = $clog2(CYCLE_CLKS);
    logic [TW-1:0] tick_cnt_reg;
    logic tick;
    assign tick = (tick_cnt_reg == TW'(CYCLE_CLKS - 1));

    // The program cycle is a free count, so a slow bus never stretches it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------------
    logic alarm_en_reg, calc_pwr_reg, allow_mode_reg;
    vdm_mode_e mode_reg;
    logic [13:0] thresh_reg;
    logic [18:0] delay_reg;
    logic [5:0] evt_sel_reg;
    logic wr_en, rd_setup;
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;

    // Writes take effect immediately; out-of-range threshold and delay values are dropped whole, an out-of-range mode keeps only the old mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_en_reg <= `VDM_RST_EN;
            calc_pwr_reg <= `VDM_RST_PWR;
            allow_mode_reg <= 1'b0;
            mode_reg <= MODE_ON;
            thresh_reg <= `VDM_RST_THRESH;
            delay_reg <= `VDM_RST_DELAY;
            evt_sel_reg <= `VDM_RST_EVTSEL;
        end else if (wr_en) begin
            case (paddr)
                `VDM_OFS_CTRL: begin
                    alarm_en_reg <= pwdata[`VDM_CTRL_EN];
                    calc_pwr_reg <= pwdata[`VDM_CTRL_PWR];
                    allow_mode_reg <= pwdata[`VDM_CTRL_ALLOW];
                    if (pwdata[`VDM_CTRL_MODE_LO+:3] <= 3'(MODE_OFF)) begin
                        mode_reg <= vdm_mode_e'(pwdata[`VDM_CTRL_MODE_LO+:3]);
                    end
                end
                `VDM_OFS_THRESH: begin
                    if (pwdata[31:0] >= 32'(`VDM_THRESH_MIN) &&
                        pwdata[31:0] <= 32'(`VDM_THRESH_MAX)) begin
                        thresh_reg <= pwdata[13:0];
                    end
                end
                `VDM_OFS_DELAY: begin
                    if (pwdata[31:0] <= 32'(`VDM_DELAY_MAX)) begin
                        delay_reg <= pwdata[18:0];
                    end
                end
                `VDM_OFS_EVTSEL: evt_sel_reg <= pwdata[5:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Measurement latch and blocking sampling
    // ------------------------------------------------------------------------
    vdm_meas_s [2:0] meas_reg;
    logic blk_s1_reg, blk_s2_reg, blk_cyc_reg;

    // The front end refreshes every 5 ms; the last set seen is evaluated.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_reg <= '0;
        end else if (meas_valid) begin
            meas_reg <= meas_in;
        end
    end

    // Two flops for the pin, then one held copy per program cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_s1_reg <= 1'b0;
            blk_s2_reg <= 1'b0;
            blk_cyc_reg <= 1'b0;
        end else begin
            blk_s1_reg <= block_in;
            blk_s2_reg <= blk_s1_reg;
            if (tick) begin
                blk_cyc_reg <= blk_s2_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Distortion comparison
    // ------------------------------------------------------------------------
    // Ratios are compared by cross multiplication, so no divider is needed.
    // Returns {over threshold, under release level}.
    function automatic logic [1:0] thd_cmp(input logic [15:0] h, input logic [15:0] f,
                                           input logic [13:0] t, input logic pwr);
        logic [63:0] h64, f64, t64, lo, ro, lu, ru;
        h64 = {48'h0, h};
        f64 = {48'h0, f};
        t64 = {50'h0, t};
        if (pwr) begin
            lo = h64 * `VDM_SCALE;
            ro = t64 * f64;
            lu = lo * `VDM_PCT;
            ru = `VDM_REL_PCT * ro;
        end else begin
            lo = h64 * `VDM_SCALE * `VDM_SCALE;
            ro = t64 * t64 * f64;
            lu = lo * `VDM_PCT * `VDM_PCT;
            ru = `VDM_REL_PCT * `VDM_REL_PCT * ro;
        end
        thd_cmp = {lo > ro, lu < ru};
    endfunction

    logic [2:0] over_v, under_v;
    for (genvar i = 0; i < 3; i++) begin : g_ph
        assign {over_v[i], under_v[i]} = thd_cmp(meas_reg[i].harm_sq, meas_reg[i].fund_sq,
                                                 thresh_reg, calc_pwr_reg);
    end

    // ------------------------------------------------------------------------
    // Pick-up and condition state
    // ------------------------------------------------------------------------
    logic picked_reg, picked_now, active, blk_eff;
    vdm_cond_e state_reg, state_next;
    logic [18:0] timer_reg;
    logic start_next, alarm_next, blocked_next;

    assign active = alarm_en_reg && (mode_reg != MODE_OFF);
    assign blk_eff = blk_cyc_reg || mode_reg == MODE_BLOCKED || mode_reg == MODE_TEST_BLOCKED;
    // Hysteresis: any phase over picks up, all phases under release.
    assign picked_now = picked_reg ? !(&under_v) : (|over_v);

    always_comb begin
        state_next = state_reg;
        if (!active) begin
            state_next = COND_NORMAL;
        end else if (tick) begin
            case (state_reg)
                COND_NORMAL: begin
                    if (picked_now) begin
                        state_next = blk_eff ? COND_BLOCKED : COND_START;
                    end
                end
                COND_START: begin
                    if (!picked_now || blk_eff) begin
                        state_next = COND_NORMAL;
                    end else if (timer_reg + 19'h1 >= delay_reg) begin
                        state_next = COND_ALARM;
                    end
                end
                COND_ALARM: begin
                    if (!picked_now || blk_eff) begin
                        state_next = COND_NORMAL;
                    end
                end
                COND_BLOCKED: begin
                    if (!picked_now || !blk_eff) begin
                        state_next = COND_NORMAL;
                    end
                end
                default: state_next = COND_NORMAL;
            endcase
        end
    end

    assign start_next = (state_next == COND_START) || (state_next == COND_ALARM);
    assign alarm_next = (state_next == COND_ALARM);
    assign blocked_next = (state_next == COND_BLOCKED);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= COND_NORMAL;
            picked_reg <= 1'b0;
            start_out <= 1'b0;
            alarm_out <= 1'b0;
            blocked_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (!active) begin
                picked_reg <= 1'b0;
            end else if (tick) begin
                picked_reg <= picked_now;
            end
            start_out <= start_next;
            alarm_out <= alarm_next;
            blocked_out <= blocked_next;
        end
    end

    // Definite-time counter in program cycles of 5 ms each.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= '0;
        end else if (state_next != COND_START) begin
            timer_reg <= '0;
        end else if (tick && state_reg == COND_START) begin
            timer_reg <= timer_reg + 19'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Events, counters and log
    // ------------------------------------------------------------------------
    logic [5:0] ev_set, ev_pend_reg, ev_grant;
    logic [2:0] ev_code;
    logic [15:0] cnt_reg [3];
    logic [2:0] cnt_clr;
    vdm_log_s log_mem [`VDM_LOG_DEPTH];
    logic [3:0] log_head_reg, log_count_reg;

    // Off mode clears the outputs silently, so no off events leak out.
    assign ev_set = (mode_reg == MODE_OFF) ? 6'h00 :
        {!blocked_next && blocked_out, blocked_next && !blocked_out,
         !alarm_next && alarm_out, alarm_next && !alarm_out,
         !start_next && start_out, start_next && !start_out};
    assign ev_grant = ev_pend_reg & (~ev_pend_reg + 6'h01);
    assign cnt_clr = (wr_en && paddr == `VDM_OFS_CNT_CLR) ? pwdata[2:0] : 3'h0;

    always_comb begin
        ev_code = 3'h0;
        for (int k = 0; k < 6; k++) begin
            if (ev_grant[k]) begin
                ev_code = 3'(k);
            end
        end
    end

    // Events drain one per clock; a new event wins over the drain of its bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_pend_reg <= '0;
            event_out <= '0;
        end else begin
            ev_pend_reg <= (ev_pend_reg & ~ev_grant) | (ev_set & evt_sel_reg);
            event_out.valid <= |ev_grant;
            event_out.code <= ev_code;
            event_out.stamp <= time_ms;
        end
    end

    // A clear and an increment together leave a count of one.
    for (genvar c = 0; c < 3; c++) begin : g_cnt
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg[c] <= '0;
            end else if (cnt_clr[c] || ev_set[2*c]) begin
                cnt_reg[c] <= (cnt_clr[c] ? 16'h0 : cnt_reg[c]) + 16'(ev_set[2*c]);
            end
        end
    end

    // At most one on transition occurs per program cycle.
    always_ff @(posedge pclk) begin
        if (ev_set[0] || ev_set[2] || ev_set[4]) begin
            log_mem[log_head_reg] <= '{stamp: time_ms, group: active_group,
                code: ev_set[4] ? 3'h4 : (ev_set[2] ? 3'h2 : 3'h0),
                phase: meas_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_head_reg <= '0;
            log_count_reg <= '0;
        end else if (ev_set[0] || ev_set[2] || ev_set[4]) begin
            log_head_reg <= (log_head_reg == 4'(`VDM_LOG_DEPTH - 1)) ? 4'h0 :
                log_head_reg + 4'h1;
            if (log_count_reg != 4'(`VDM_LOG_DEPTH)) begin
                log_count_reg <= log_count_reg + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------------
    logic [31:0] rd_data;
    logic rd_err;
    logic [6:0] ent;
    vdm_log_s le;
    assign ent = paddr[11:5] - `VDM_OFS_LOG_BASE;
    assign le = log_mem[ent[3:0]];

    always_comb begin
        rd_data = 32'h0;
        rd_err = 1'b0;
        case (paddr)
            `VDM_OFS_CTRL: rd_data = {26'h0, allow_mode_reg, mode_reg, calc_pwr_reg, alarm_en_reg};
            `VDM_OFS_THRESH: rd_data = {18'h0, thresh_reg};
            `VDM_OFS_DELAY: rd_data = {13'h0, delay_reg};
            `VDM_OFS_EVTSEL: rd_data = {26'h0, evt_sel_reg};
            `VDM_OFS_STATUS: rd_data = {24'h0, blk_cyc_reg, picked_reg, allow_mode_reg,
                allow_mode_reg ? mode_reg : MODE_ON, state_reg};
            `VDM_OFS_CNT_START: rd_data = {16'h0, cnt_reg[0]};
            `VDM_OFS_CNT_ALARM: rd_data = {16'h0, cnt_reg[1]};
            `VDM_OFS_CNT_BLOCK: rd_data = {16'h0, cnt_reg[2]};
            `VDM_OFS_CNT_CLR: rd_data = 32'h0;
            `VDM_OFS_LOG_HEAD: rd_data = {24'h0, log_count_reg, log_head_reg};
            default: begin
                if (ent < 7'(`VDM_LOG_DEPTH) && paddr[11:5] >= `VDM_OFS_LOG_BASE
                    && paddr[4:2] <= 3'h4 && paddr[1:0] == 2'h0) begin
                    case (paddr[4:2])
                        3'h0: rd_data = le.stamp[31:0];
                        3'h1: rd_data = {le.stamp[47:32], 10'h0, le.group, le.code};
                        3'h2: rd_data = le.phase[0];
                        3'h3: rd_data = le.phase[1];
                        default: rd_data = le.phase[2];
                    endcase
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // Answer is prepared in the setup cycle, so every access has no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup && rd_err;
            prdata <= (rd_setup && !pwrite) ? rd_data : 32'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pick_free;
        tick && active && state_reg == COND_NORMAL && picked_now && !blk_eff;
    endsequence
    sequence s_run_out;
        tick && active && state_reg == COND_START && picked_now && !blk_eff &&
            timer_reg + 19'h1 >= delay_reg;
    endsequence

    property p_enable_gate;
        !alarm_en_reg |=> !start_out && !alarm_out && !blocked_out;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("output while disabled");
    property p_hold_picked;
        tick && active && picked_reg && !(&under_v) |=> picked_reg;
    endproperty
    a_hold_picked: assert property (p_hold_picked) else $error("early release");
    property p_any_phase;
        tick && active && !picked_reg && (|over_v) |=> picked_reg;
    endproperty
    a_any_phase: assert property (p_any_phase) else $error("missed pick-up");
    property p_thresh_range;
        thresh_reg >= `VDM_THRESH_MIN && thresh_reg <= `VDM_THRESH_MAX;
    endproperty
    a_thresh_range: assert property (p_thresh_range) else $error("threshold range");
    property p_blk_hold;
        !tick |=> $stable(blk_cyc_reg);
    endproperty
    a_blk_hold: assert property (p_blk_hold) else $error("block sampled mid-cycle");
    property p_start;
        s_pick_free |=> start_out && !blocked_out && !alarm_out ##1 timer_reg == 19'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not raised");
    property p_blocked;
        tick && active && state_reg == COND_NORMAL && picked_now && blk_eff
            |=> blocked_out && !start_out;
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked not raised");
    property p_block_drop;
        tick && start_out && blk_eff |=> !start_out && !alarm_out;
    endproperty
    a_block_drop: assert property (p_block_drop) else $error("start kept under block");
    property p_alarm;
        s_run_out |=> alarm_out && start_out;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm late");
    property p_off;
        mode_reg == MODE_OFF && $past(mode_reg) == MODE_OFF |=> !event_out.valid && !start_out;
    endproperty
    a_off: assert property (p_off) else $error("activity in off mode");
    property p_count;
        ev_set[0] && !cnt_clr[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h1;
    endproperty
    a_count: assert property (p_count) else $error("start count missed");
endmodule

// [testbench/vdm_front.sv]
// Behavioural front end: spectrum feed, blocking pin and millisecond clock.
// Assumes it shares pclk and presetn with the monitor.
`timescale 1ns/1ps
module vdm_front (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] harm,
    input wire logic blk,
    output logic meas_valid,
    output vdm_pkg::vdm_meas_s [2:0] meas_in,
    output logic block_in,
    output logic [47:0] time_ms
);
    import vdm_pkg::*;
    logic [1:0] cnt_reg;
    // Only phase 1 is disturbed, so a single phase must be enough to pick up.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 2'h0;
            meas_valid <= 1'b0;
            meas_in <= '0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
            meas_valid <= (cnt_reg == 2'h0);
            meas_in <= {{16'h0, 16'h2710}, {harm, 16'h2710}, {16'h0, 16'h2710}};
        end
    end
    // The bench raises blk many cycles before its 200-cycle delay runs out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_in <= 1'b0;
            time_ms <= 48'h0;
        end else begin
            block_in <= blk;
            time_ms <= time_ms + 48'h1;
        end
    end
endmodule

// [testbench/voltage_thd_alarm_monitor_bench.sv]
// Self-checking bench of the voltage distortion monitor.
// Assumes the front-end model and a program tick of 8 clocks.
`timescale 1ns/1ps
`include "vdm_consts.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module voltage_thd_alarm_monitor_bench;
    import vdm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, meas_valid, block_in, e, blk = 1'b0;
    logic start_out, alarm_out, blocked_out;
    logic [15:0] harm = 16'h0;
    logic [47:0] time_ms, prev_t = 48'h0;
    logic [5:0] seen = 6'h0;
    logic [2:0] o;
    vdm_meas_s [2:0] meas_in;
    vdm_evt_s event_out;
    int errors = 0, n_checks = 0;
    logic [44:0] rows [9] = '{{1'b0, 12'h000, 32'h1}, {1'b0, 12'h004, 32'h3e8},
        {1'b0, 12'h008, 32'h7d0}, {1'b0, 12'h00c, 32'h3f}, {1'b0, 12'h010, 32'h0},
        {1'b0, 12'h014, 32'h0}, {1'b0, 12'h018, 32'h0}, {1'b0, 12'h01c, 32'h0},
        {1'b1, 12'h0fc, 32'h0}};
    assign o = {blocked_out, alarm_out, start_out};
    always #10 pclk = ~pclk;
    vdm_monitor #(.CYCLE_CLKS(8)) vdm_monitor_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
        .meas_in(meas_in), .block_in(block_in), .time_ms(time_ms), .active_group(3'h2),
        .start_out(start_out), .alarm_out(alarm_out), .blocked_out(blocked_out),
        .event_out(event_out));
    vdm_front vdm_front_i (.pclk(pclk), .presetn(presetn), .harm(harm), .blk(blk),
        .meas_valid(meas_valid), .meas_in(meas_in), .block_in(block_in), .time_ms(time_ms));
    // Stamps are compared with the time the monitor saw at the launch edge.
    always @(posedge pclk) begin
        if (event_out.valid === 1'b1) begin
            `CHK("stamp", prev_t, event_out.stamp)
            seen[event_out.code] <= 1'b1;
        end
        prev_t <= time_ms;
    end
    // APB transfer; the wait is bounded so a dead slave ends as a mismatch.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK("rdata", x, r)
    endtask
    task automatic wt(input int i, input logic v);
        int k;
        k = 0;
        while (o[i] !== v && k < 400) begin @(posedge pclk); k++; end
        `CHK("output", v, o[i])
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under 20000 clocks.
    initial begin
        #400000;
        errors++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[j]) begin
            apb(1'b0, rows[j][43:32], 32'h0);
            `CHK("row", rows[j], {e, rows[j][43:32], r})
        end
        apb(1'b1, 12'h004, 32'h5);
        rd(12'h004, 32'h3e8);
        apb(1'b1, 12'h008, 32'h2);
        harm <= 16'h00c8;
        wt(0, 1'b1);
        wt(1, 1'b1);
        harm <= 16'h0;
        wt(0, 1'b0);
        `CHK("alarm", 1'b0, alarm_out)
        rd(12'h018, 32'h1);
        apb(1'b1, 12'h008, 32'hc8);
        harm <= 16'h00c8;
        wt(0, 1'b1);
        blk <= 1'b1;
        wt(0, 1'b0);
        wt(2, 1'b1);
        `CHK("start", 1'b0, start_out)
        harm <= 16'h0;
        wt(2, 1'b0);
        blk <= 1'b0;
        rd(12'h01c, 32'h1);
        rd(12'h024, 32'h44);
        rd(12'h104, 32'h10);
        rd(12'h10c, 32'h00c82710);
        `CHK("events", 6'h3f, seen)
        // Power ratio: a 2 percent distortion stays under a 10 percent threshold.
        apb(1'b1, 12'h000, 32'h3);
        harm <= 16'h00c8;
        repeat (40) @(posedge pclk);
        `CHK("power", 3'h0, o)
        harm <= 16'h07d0;
        wt(0, 1'b1);
        harm <= 16'h0;
        wt(0, 1'b0);
        apb(1'b1, 12'h000, 32'h25);
        rd(12'h010, 32'h24);
        apb(1'b1, 12'h000, 32'h11);
        harm <= 16'h00c8;
        repeat (40) @(posedge pclk);
        `CHK("off", 3'h0, o)
        apb(1'b1, 12'h000, 32'h0);
        repeat (40) @(posedge pclk);
        `CHK("disabled", 3'h0, o)
        harm <= 16'h0;
        apb(1'b1, 12'h020, 32'h7);
        rd(12'h014, 32'h0);
        close_out();
    end
endmodule
